/* File: adc_ctrl_defines.vh */
// Register offsets, field positions, write masks, reset values and mode codes
// for the converter control register file. Definitions only.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

`define OFS_CONTROL_A        5'h00
`define OFS_CONTROL_B        5'h01
`define OFS_CONTROL_C        5'h02
`define OFS_CONTROL_D        5'h03
`define OFS_CONTROL_E        5'h04
`define OFS_SAMPLE_LEN       5'h05
`define OFS_INPUT_SELECT     5'h06
`define OFS_COMMAND          5'h08
`define OFS_EVENT_CONTROL    5'h09
`define OFS_INT_CONTROL      5'h0a
`define OFS_INT_FLAGS        5'h0b
`define OFS_DEBUG_CONTROL    5'h0c
`define OFS_TEMP_BYTE        5'h0d
`define OFS_RESULT_LO        5'h10
`define OFS_RESULT_HI        5'h11
`define OFS_WIN_LOW_LO       5'h12
`define OFS_WIN_LOW_HI       5'h13
`define OFS_WIN_HIGH_LO      5'h14
`define OFS_WIN_HIGH_HI      5'h15
`define OFS_CALIBRATION      5'h16

`define BIT_ENABLE           0
`define BIT_RES_SELECT       2
`define BIT_STANDBY_RUN      7
`define BIT_SAMPLE_CAP       6
`define REFERENCE_SELECT_MSB           5
`define REFERENCE_SELECT_LSB           4
`define DIV_MSB              2
`define DIV_LSB              0
`define BIT_RESULT_READY     0
`define BIT_WINDOW_MATCH     1

`define MASK_CONTROL_A       8'h85
`define MASK_CONTROL_B       8'h07
`define MASK_CONTROL_C       8'h77
`define MASK_CONTROL_E       8'h07
`define MASK_SAMPLE_LEN      8'h1f
`define MASK_INPUT_SELECT    8'h1f
`define MASK_FLAGS           8'h03
`define MASK_CALIBRATION     8'h01

`define RESET_BYTE           8'h00
`define ACC_RESERVED         3'h7
`define REF_INTERNAL         2'h0
`define REF_SUPPLY           2'h1

`define WIN_NONE             3'h0
`define WIN_BELOW            3'h1
`define WIN_ABOVE            3'h2
`define WIN_INSIDE           3'h3
`define WIN_OUTSIDE          3'h4

`endif

/* File: adc_control_register_file.v */
// Control and configuration register file of a 10-bit successive-approximation
// converter, with a sequencer that drives the analogue core and accumulates.
// Assumes a classic Wishbone master on clk and a core that pulses coreDone.
// Operation
// - Standby halts converter unless standby-run set
// - Resolution clear: store full 10-bit values
// - Resolution set: drop two LSBs first
// - Control A bit 0 enables converter
// - Accumulate 1 to 64 samples; 7 reserved
// - Control C bit 6 selects sample capacitance
// - Reference select: internal or supply rail
// - Decode offsets 0x00-0x16, skip reserved holes
// - Prescaler divides clock by 2 to 256
// - Window compare once after final sample
// - Completion sets result-ready, clears start bit
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"

module adc_control_register_file
(
    // Clock and reset.
    input  wire        clk,
    input  wire        arst_n,
    // Wishbone slave.
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [6:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // System state and trigger.
    input  wire        standbyActive,
    input  wire        startEvent,
    // Analogue core.
    output reg         coreStart,
    input  wire        coreDone,
    input  wire [9:0]  coreData,
    output wire        coreEnable,
    output wire        converterClockTick,
    output wire        sampleCapSelect,
    output wire [1:0]  referenceSelect,
    output wire        referenceValid,
    output wire [4:0]  inputSelect,
    output wire [4:0]  sampleLength,
    output wire [7:0]  delayControl,
    // Interrupt.
    output wire        irq
);

    reg [7:0]  controlA_reg;
    reg [7:0]  controlB_reg;
    reg [7:0]  controlC_reg;
    reg [7:0]  controlD_reg;
    reg [7:0]  controlE_reg;
    reg [7:0]  sampleLen_reg;
    reg [7:0]  inputSel_reg;
    reg        startConv_reg;
    reg        eventEnable_reg;
    reg [7:0]  intMask_reg;
    reg [7:0]  interrupt_flags_reg;
    reg [7:0]  interrupt_flags_next;
    reg        debugRun_reg;
    reg [7:0]  tempByte_reg;
    reg [15:0] result_reg;
    reg [15:0] winLow_reg;
    reg [15:0] winHigh_reg;
    reg        calibration_reg;
    reg [7:0]  divCount_reg;
    reg        busy_reg;
    reg [6:0]  sampleCount_reg;
    reg [15:0] accum_reg;
    reg        eventLast_reg;

    // Number of samples for an accumulation code; the reserved code acts as one.
    function [6:0] samplesFor;
        input [2:0] code;
        begin
            if (code == `ACC_RESERVED)
                samplesFor = 7'h01;
            else
                samplesFor = 7'h01 << code;
        end
    endfunction

    // Byte lane value at a given offset; holes and reserved bits return zero.
    function [7:0] readByte;
        input [4:0] ofs;
        begin
            case (ofs)
                `OFS_CONTROL_A:     readByte = controlA_reg;
                `OFS_CONTROL_B:     readByte = controlB_reg;
                `OFS_CONTROL_C:     readByte = controlC_reg;
                `OFS_CONTROL_D:     readByte = controlD_reg;
                `OFS_CONTROL_E:     readByte = controlE_reg;
                `OFS_SAMPLE_LEN:    readByte = sampleLen_reg;
                `OFS_INPUT_SELECT:  readByte = inputSel_reg;
                `OFS_COMMAND:       readByte = {7'h00, startConv_reg};
                `OFS_EVENT_CONTROL: readByte = {7'h00, eventEnable_reg};
                `OFS_INT_CONTROL:   readByte = intMask_reg;
                `OFS_INT_FLAGS:     readByte = interrupt_flags_reg;
                `OFS_DEBUG_CONTROL: readByte = {7'h00, debugRun_reg};
                `OFS_TEMP_BYTE:     readByte = tempByte_reg;
                `OFS_RESULT_LO:     readByte = result_reg[7:0];
                `OFS_RESULT_HI:     readByte = result_reg[15:8];
                `OFS_WIN_LOW_LO:    readByte = winLow_reg[7:0];
                `OFS_WIN_LOW_HI:    readByte = winLow_reg[15:8];
                `OFS_WIN_HIGH_LO:   readByte = winHigh_reg[7:0];
                `OFS_WIN_HIGH_HI:   readByte = winHigh_reg[15:8];
                `OFS_CALIBRATION:   readByte = {7'h00, calibration_reg};
                default:            readByte = 8'h00;
            endcase
        end
    endfunction

    // Bus decode: one byte register per aligned word, data in bits 7:0.
    // Only byte lane zero is looked at; a write with that lane disabled is
    // still acknowledged so that the master never waits on it.
    wire [4:0] regIndex  = wb_adr_i[6:2];
    wire       busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       byteWrite = busReq & wb_we_i & wb_sel_i[0];
    wire [7:0] wrData    = wb_dat_i[7:0];

    // Running: enabled, and either awake or allowed to run in standby.
    // Standby without the run bit is treated like a disable: the core is
    // gated off at once, so a conversion that was in flight is lost rather
    // than left half accumulated for the next wake-up.
    wire running = controlA_reg[`BIT_ENABLE]
                   & (~standbyActive | controlA_reg[`BIT_STANDBY_RUN]);

    // Prescaler: a tick every 2^(code+1) clocks.
    // The top value is formed in eight bits on purpose: for the largest code
    // the shifted constant wraps to zero and the subtraction gives 255,
    // which is the 256-clock period without a ninth counter bit.
    wire [7:0] divTop = (8'h02 << controlC_reg[`DIV_MSB:`DIV_LSB]) - 8'h01;
    assign converterClockTick = running & (divCount_reg == divTop);

    // Resolution handling happens before accumulation. The short result is
    // right-aligned, so software reads it without a shift.
    wire [9:0]  sampleValue = controlA_reg[`BIT_RES_SELECT] ?
                              {2'b00, coreData[9:2]} :
                              coreData;
    // Sixty-four full-scale samples reach 65472, so sixteen bits never overflow.
    wire [15:0] accumNext   = accum_reg + {6'h00, sampleValue};
    wire [6:0]  totalSamples = samplesFor(controlB_reg[2:0]);
    wire        lastSample  = busy_reg & coreDone
                              & (sampleCount_reg + 7'h01 == totalSamples);

    // Window comparison on the final accumulated value only.
    // Reserved mode codes compare nothing, so they can never raise the flag.
    reg winHit;
    always @*
    begin
        case (controlE_reg[2:0])
            `WIN_BELOW:   winHit = accumNext < winLow_reg;
            `WIN_ABOVE:   winHit = accumNext > winHigh_reg;
            `WIN_INSIDE:  winHit = (accumNext > winLow_reg) & (accumNext < winHigh_reg);
            `WIN_OUTSIDE: winHit = (accumNext < winLow_reg) | (accumNext > winHigh_reg);
            default:      winHit = 1'b0;
        endcase
    end

    wire eventRise = startEvent & ~eventLast_reg & eventEnable_reg;
    wire cmdStart  = byteWrite & (regIndex == `OFS_COMMAND) & wrData[0];

    // Set wins over a same-cycle write-one-to-clear.
    wire [7:0] flagSet = {6'h00, lastSample & winHit, lastSample};
    wire [7:0] flagClr = (byteWrite & (regIndex == `OFS_INT_FLAGS)) ?
                         (wrData & `MASK_FLAGS) : 8'h00;

    // Next flag state: a completion that lands in the same cycle as a
    // software clear must not be lost, so the set term is applied last.
    always @*
    begin
        interrupt_flags_next = interrupt_flags_reg & ~flagClr;
        interrupt_flags_next = interrupt_flags_next | flagSet;
    end

    // The interrupt is a level: it stays up until software clears the flag
    // or masks it, and a flag set while masked fires as soon as it is unmasked.

    assign irq               = |(interrupt_flags_reg & intMask_reg);
    assign coreEnable        = running;
    assign sampleCapSelect   = controlC_reg[`BIT_SAMPLE_CAP];
    assign referenceSelect   = controlC_reg[`REFERENCE_SELECT_MSB:`REFERENCE_SELECT_LSB];
    // Reserved reference codes are passed on but marked invalid, so the core
    // can refuse to convert against an undefined reference.
    assign referenceValid    = (referenceSelect == `REF_INTERNAL)
                               | (referenceSelect == `REF_SUPPLY);
    assign inputSelect       = inputSel_reg[4:0];
    assign sampleLength      = sampleLen_reg[4:0];
    assign delayControl      = controlD_reg;

    // Bus answer: ack one cycle after the request is taken, never back to back,
    // but a master that holds its strobe a cycle past the ack cycle gets a second ack.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= busReq;
    end

    // Read data is registered with the ack and then held until the next read,
    // so a slow master may still take it after the ack has dropped.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h00000000;
        else if (busReq & ~wb_we_i)
            wb_dat_o <= {24'h000000, readByte(regIndex)};
    end

    // Configuration registers.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            controlA_reg    <= `RESET_BYTE;
            controlB_reg    <= `RESET_BYTE;
            controlC_reg    <= `RESET_BYTE;
            controlD_reg    <= `RESET_BYTE;
            controlE_reg    <= `RESET_BYTE;
            sampleLen_reg   <= `RESET_BYTE;
            inputSel_reg    <= `RESET_BYTE;
            eventEnable_reg <= 1'b0;
            intMask_reg     <= `RESET_BYTE;
            debugRun_reg    <= 1'b0;
            tempByte_reg    <= `RESET_BYTE;
            calibration_reg       <= 1'b0;
        end
        else if (byteWrite)
        begin
            case (regIndex)
                `OFS_CONTROL_A:     controlA_reg    <= wrData & `MASK_CONTROL_A;
                `OFS_CONTROL_B:     controlB_reg    <= wrData & `MASK_CONTROL_B;
                `OFS_CONTROL_C:     controlC_reg    <= wrData & `MASK_CONTROL_C;
                `OFS_CONTROL_D:     controlD_reg    <= wrData;
                `OFS_CONTROL_E:     controlE_reg    <= wrData & `MASK_CONTROL_E;
                `OFS_SAMPLE_LEN:    sampleLen_reg   <= wrData & `MASK_SAMPLE_LEN;
                `OFS_INPUT_SELECT:  inputSel_reg    <= wrData & `MASK_INPUT_SELECT;
                `OFS_EVENT_CONTROL: eventEnable_reg <= wrData[0];
                `OFS_INT_CONTROL:   intMask_reg     <= wrData & `MASK_FLAGS;
                `OFS_DEBUG_CONTROL: debugRun_reg    <= wrData[0];
                `OFS_TEMP_BYTE:     tempByte_reg    <= wrData;
                `OFS_CALIBRATION:   calibration_reg       <= wrData[0];
                default:            calibration_reg       <= calibration_reg;
            endcase
        end
    end

    // Window thresholds: each byte is written on its own and nothing latches
    // the other half, so software that changes a threshold between two
    // conversions may briefly compare against a mixed value.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            winLow_reg  <= 16'h0000;
            winHigh_reg <= 16'h0000;
        end
        else if (byteWrite)
        begin
            case (regIndex)
                `OFS_WIN_LOW_LO:  winLow_reg[7:0]   <= wrData;
                `OFS_WIN_LOW_HI:  winLow_reg[15:8]  <= wrData;
                `OFS_WIN_HIGH_LO: winHigh_reg[7:0]  <= wrData;
                `OFS_WIN_HIGH_HI: winHigh_reg[15:8] <= wrData;
                default:          winLow_reg        <= winLow_reg;
            endcase
        end
    end

    // Prescaler counter; held cleared while not running to save switching.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            divCount_reg <= 8'h00;
        else if (!running || converterClockTick)
            divCount_reg <= 8'h00;
        else
            divCount_reg <= divCount_reg + 8'h01;
    end

    // Edge detector for the trigger input; it resets to the idle low level, so a trigger
    // already high when reset ends looks like a rising edge until the first clock.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            eventLast_reg <= 1'b0;
        else
            eventLast_reg <= startEvent;
    end

    // Interrupt flags.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            interrupt_flags_reg <= `RESET_BYTE;
        else
            interrupt_flags_reg <= interrupt_flags_next;
    end

    // Conversion sequencer. A start request is first latched into the command
    // bit and the core is started one cycle later, so software always sees the
    // bit set before the conversion can complete.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startConv_reg   <= 1'b0;
            busy_reg        <= 1'b0;
            coreStart       <= 1'b0;
            sampleCount_reg <= 7'h00;
            accum_reg       <= 16'h0000;
            result_reg      <= 16'h0000;
        end
        else
        begin
            coreStart     <= 1'b0;
            if (!running)
            begin
                // A disabled or halted converter drops any conversion in flight.
                busy_reg      <= 1'b0;
                startConv_reg <= 1'b0;
            end
            else if (!busy_reg)
            begin
                if (startConv_reg)
                begin
                    busy_reg        <= 1'b1;
                    coreStart       <= 1'b1;
                    sampleCount_reg <= 7'h00;
                    accum_reg       <= 16'h0000;
                end
                else if (cmdStart || eventRise)
                begin
                    // The command bit reads back as one for the whole conversion.
                    startConv_reg <= 1'b1;
                end
            end
            else if (coreDone)
            begin
                if (lastSample)
                begin
                    result_reg    <= accumNext;
                    busy_reg      <= 1'b0;
                    startConv_reg <= 1'b0;
                end
                else
                begin
                    accum_reg       <= accumNext;
                    sampleCount_reg <= sampleCount_reg + 7'h01;
                    coreStart       <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: adc_ctrl_checker_properties.sv */
// Port checker for the converter register file.
// Assumes one clock domain, clk, with arst_n asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker
(
    // Clock and reset.
    input wire logic        clk,
    input wire logic        arst_n,
    // Register bus.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Core side.
    input wire logic        coreStart,
    input wire logic        coreDone,
    input wire logic        coreEnable,
    input wire logic        converterClockTick,
    input wire logic [1:0]  referenceSelect,
    input wire logic        referenceValid,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_rdata_upper: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits set");
    a_tick_gated: assert property (
        converterClockTick |-> coreEnable) else $error("tick while off");
    a_tick_single: assert property (
        converterClockTick |=> !converterClockTick) else $error("tick too long");
    a_start_enabled: assert property (
        coreStart |-> $past(coreEnable)) else $error("start while off");
    a_ref_reserved: assert property (
        referenceSelect[1] |-> !referenceValid) else $error("reserved ref valid");
    a_irq_cause: assert property (
        $rose(irq) |-> wb_ack_o || $past(wb_ack_o) || $past(coreDone))
        else $error("irq without cause");
endmodule
bind adc_control_register_file adc_ctrl_checker adc_ctrl_checker_i
(
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coreStart(coreStart),
    .coreDone(coreDone), .coreEnable(coreEnable),
    .converterClockTick(converterClockTick), .referenceSelect(referenceSelect),
    .referenceValid(referenceValid), .irq(irq)
);
`default_nettype wire

/* File: analog_core_model.sv */
// Behavioural model of the analogue conversion core.
// Assumes coreStart is a one-cycle pulse sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
(
    // Clock.
    input  wire logic       clk,
    // Sample request and answer.
    input  wire logic       coreStart,
    input  wire logic       slow,
    input  wire logic [9:0] sampleValue,
    output var  logic       coreDone = 1'b0,
    output var  logic [9:0] coreData = 10'h000
);
    integer count = 0;
    // Data toggles outside the done cycle, so a late capture shows up as a wrong sum.
    always @(posedge clk)
    begin
        coreDone <= 1'b0;
        coreData <= ~coreData;
        if (coreStart)
            count <= slow ? 9 : 1;
        else if (count != 0)
            count <= count - 1;
        if (!coreStart && count == 1)
        begin
            coreDone <= 1'b1;
            coreData <= sampleValue;
        end
    end
endmodule
`default_nettype wire

/* File: adc_control_register_file_tb_top.sv */
// Bench for the converter register file: register walk, conversions,
// standby, enable and divider. Assumes the core model of analog_core_model.sv.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
`default_nettype none
module adc_control_register_file_tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [6:0]  adr = 7'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack, standby = 1'b0, evt = 1'b0, slow = 1'b0;
    logic [9:0]  sampleValue = 10'h000, coreData;
    logic        coreStart, coreDone, coreEnable, tick, capSel, refValid, irq;
    logic [1:0]  reference_select;
    logic [4:0]  inSel, sample_length;
    logic [7:0]  dly;
    logic [7:0]  q;
    integer      fails = 0, samplesChecked = 0, i, n;
    localparam logic [7:0] MASKS [0:22] = '{8'h85, 8'h07, 8'h77, 8'hff, 8'h07, 8'h1f,
        8'h1f, 0, 0, 8'h01, 8'h03, 0, 8'h01, 8'hff, 0, 0, 0, 0, 8'hff, 8'hff, 8'hff,
        8'hff, 8'h01};
    always #12.5 clk = ~clk;
    adc_control_register_file adc_control_register_file_i
    (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .standbyActive(standby), .startEvent(evt),
        .coreStart(coreStart), .coreDone(coreDone), .coreData(coreData),
        .coreEnable(coreEnable), .converterClockTick(tick), .sampleCapSelect(capSel),
        .referenceSelect(reference_select), .referenceValid(refValid), .inputSelect(inSel),
        .sampleLength(sample_length), .delayControl(dly), .irq(irq)
    );
    analog_core_model analog_core_model_i
    (
        .clk(clk), .coreStart(coreStart), .slow(slow), .sampleValue(sampleValue),
        .coreDone(coreDone), .coreData(coreData)
    );
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] r, input logic [7:0] d,
                       input logic s);
        integer k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {r, 2'b00};
        sel <= {3'h0, s};
        wdat <= {24'h0, d};
        for (k = 0; k < 16 && ack !== 1'b1; k++)
            @(posedge clk);
        chk("bus ack", 1, ack);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] r, input logic [7:0] d);
        bus(1'b1, r, d, 1'b1);
    endtask
    task automatic rc(input logic [4:0] r, input logic [7:0] e);
        bus(1'b0, r, 8'h00, 1'b1);
        chk($sformatf("register %h", r), e, q);
    endtask
    task automatic gap();
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (tick !== 1'b1 && n < 600);
    endtask
    task automatic conv(input logic [2:0] c, input logic [7:0] ctlA, input logic [9:0] v,
                        input logic [7:0] fl, input logic ev);
        logic [15:0] e;
        e = 16'(ctlA[2] ? v >> 2 : v) * 16'(c == 3'h7 ? 1 : 1 << c);
        wr(5'h01, {5'h0, c});
        wr(5'h00, ctlA);
        sampleValue <= v;
        slow <= ~slow;
        if (ev)
            evt <= 1'b1;
        else
            wr(`OFS_COMMAND, 8'h01);
        for (n = 0; n < 2000 && irq !== 1'b1; n++)
            @(posedge clk);
        evt <= 1'b0;
        rc(`OFS_COMMAND, 8'h00);
        rc(`OFS_INT_FLAGS, fl);
        rc(`OFS_RESULT_LO, e[7:0]);
        rc(`OFS_RESULT_HI, e[15:8]);
        wr(`OFS_INT_CONTROL, 8'h00);
        chk("masked irq", 0, irq);
        wr(`OFS_INT_CONTROL, 8'h01);
        chk("unmasked irq", 1, irq);
        wr(`OFS_INT_FLAGS, 8'h03);
        chk("cleared irq", 0, irq);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // The longest conversion run, 64 slow samples at 11 cycles each, is just over 700 cycles; this leaves ample margin.
    initial
    begin
        #2000000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 23; i++)
            rc(i[4:0], 8'h00);
        for (i = 0; i < 23; i++)
        begin
            if (i != 8)
                wr(i[4:0], 8'hff);
            rc(i[4:0], MASKS[i]);
        end
        chk("cap select", 1, capSel);
        chk("reference valid", 0, refValid);
        chk("input select", 16'h001f, 16'(inSel));
        chk("sample length", 16'h001f, 16'(sample_length));
        chk("delay control", 16'h00ff, 16'(dly));
        bus(1'b1, 5'h0d, 8'h00, 1'b0);
        rc(5'h0d, 8'hff);
        for (i = 0; i < 23; i++)
            wr(i[4:0], 8'h00);
        $display("register walk done");
        wr(`OFS_INT_CONTROL, 8'h01);
        for (i = 0; i < 8; i++)
            conv(i[2:0], {5'h0, i[0], 2'h1}, 10'h2d7 ^ i[9:0], 8'h01, 1'b0);
        wr(`OFS_CONTROL_E, {5'h0, `WIN_ABOVE});
        conv(3'h2, 8'h01, 10'h001, 8'h03, 1'b0);
        wr(`OFS_CONTROL_E, 8'h00);
        $display("conversions done");
        @(posedge clk) standby <= 1'b1;
        @(negedge clk);
        chk("standby halt", 0, coreEnable);
        wr(`OFS_EVENT_CONTROL, 8'h01);
        conv(3'h0, 8'h81, 10'h155, 8'h01, 1'b1);
        @(posedge clk) standby <= 1'b0;
        wr(`OFS_CONTROL_A, 8'h00);
        @(negedge clk);
        chk("disabled", 0, coreEnable);
        wr(`OFS_COMMAND, 8'h01);
        repeat (40) @(posedge clk);
        rc(`OFS_INT_FLAGS, 8'h00);
        $display("standby and enable done");
        wr(`OFS_CONTROL_A, 8'h01);
        for (i = 0; i < 8; i++)
        begin
            wr(`OFS_CONTROL_C, {1'b0, i[0], i[1:0], 1'b0, i[2:0]});
            @(negedge clk);
            chk("cap", 16'(i[0]), 16'(capSel));
            chk("ref", 16'(i[1:0]), 16'(reference_select));
            chk("ref valid", 16'(i[1] == 1'b0), 16'(refValid));
            gap();
            gap();
            chk("divider", 16'(2 << i), 16'(n));
        end
        $display("divider done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
